//--- hw/delay_timer.sv
// Microsecond delay timer: counts ticks of a divided clock down to zero
module delay_timer
  import fdc_cmd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic    clock_i,
  input  wire logic    resetn_i,
  delay_timer_if.timer tif
);

  logic              busy_q, busy_d;
  logic              done_q, done_d;
  time_us_t          rem_q, rem_d;
  logic [TICK_W-1:0] tick_q, tick_d;

  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    rem_d  = rem_q;
    tick_d = tick_q;
    if (tif.start) begin
      // Restart wins over a running count
      busy_d = (tif.load_us != '0);
      done_d = (tif.load_us == '0);
      rem_d  = tif.load_us;
      tick_d = '0;
    end else if (busy_q) begin
      if (tick_q == TICK_W'(TICK_LEN - 1)) begin
        tick_d = '0;
        if (rem_q == time_us_t'(1)) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
        rem_d = rem_q - time_us_t'(1);
      end else begin
        tick_d = tick_q + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rem_q  <= '0;
      tick_q <= '0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      rem_q  <= rem_d;
      tick_q <= tick_d;
    end
  end

  assign tif.busy = busy_q;
  assign tif.done = done_q;

endmodule : delay_timer

//--- hw/delay_timer_if.sv
// Start/done handshake between the interpreter and one delay timer
interface delay_timer_if;
  import fdc_cmd_pkg::*;
  logic     start;
  time_us_t load_us;
  logic     busy;
  logic     done;
  modport ctrl  (output start, output load_us, input busy, input done);
  modport timer (input start, input load_us, output busy, output done);
endinterface : delay_timer_if

//--- hw/fdc_cmd_pkg.sv
// Constants, types and helpers shared by the command interpreter and its timers
// Summary of operation
// - Track command: byte-select plus two drive bits pick drive 0-3 and low/high byte.
// - Track command reads or writes the internal track byte; one result byte returned.
// - Write-select 0 returns old byte, third byte dummy; 1 stores supplied byte.
// - Timing parameters have no reset value and no reset ever changes them.
// - Timing command raises no interrupt, has no result, only writes timing registers.
// - Second timing byte bits 7-4 hold the step-interval code for all seeks.
// - Step interval ms is (16 - code), halved, x1, x1.67 or doubled by rate.
// - Second timing byte bits 3-0: post-command motor delay factor; 0 means 16.
// - Post delay is factor times rate constant chosen by the motor-timer range bit.
// - Third timing byte bits 3-0: pre-command motor delay factor; 0 means 128.
// - Pre delay is factor times rate constant chosen by the motor-timer range bit.
// - Third timing byte bit 0 selects DMA (0) or non-DMA (1) transfers.
// - Verify reads normal-mark sectors, checks address and data, passes no data.
// - Terminal count never ends verify; with count-enable, ends when count reached.
// - With count-enable and a sector count of 0, 256 sectors are verified.
// - Without count-enable, verify ends when checked sector equals last sector.
// - Second verify byte bit 7 is count-enable, choosing count or last-sector end.
// - Second verify byte bits 2-0 are head select and two drive-select bits.
// - With multi-track and count-enable, verify continues onto side 1 after side 0 runs out.
// - Last sector above sectors per side ends verify with error, no mark data.
package fdc_cmd_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 16;
  localparam int TIME_W        = 24;

  typedef logic [TIME_W-1:0] time_us_t;

  // Data rate select codes, indexes of the unit tables below
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  // Units in microseconds; fractional table entries rounded up
  localparam time_us_t STEP_UNIT_US [4] = '{24'd1000, 24'd1670, 24'd2000, 24'd500};
  localparam time_us_t OFF_UNIT_US [2][4] = '{
    '{24'd16000,  24'd26667,  24'd32000,   24'd8000},
    '{24'd512000, 24'd853334, 24'd1024000, 24'd512000}};
  localparam time_us_t ON_UNIT_US [2][4] = '{
    '{24'd1000,  24'd3334,  24'd4000,  24'd1000},
    '{24'd32000, 24'd53334, 24'd64000, 24'd32000}};

  localparam logic [7:0] STEP_CODE_SPAN  = 8'h10;
  localparam logic [7:0] OFF_FACTOR_ZERO = 8'h10;
  localparam logic [7:0] ON_FACTOR_ZERO  = 8'h80;

  localparam logic [7:0] OP_SPECIFY      = 8'h03;
  localparam logic [7:0] OP_SET_TRACK    = 8'h21;
  localparam logic [7:0] SET_TRACK_MASK  = 8'hbf;
  localparam logic [7:0] OP_VERIFY       = 8'h16;
  localparam logic [7:0] VERIFY_MASK     = 8'h1f;

  localparam logic [3:0] LEN_SPECIFY   = 4'h3;
  localparam logic [3:0] LEN_SET_TRACK = 4'h3;
  localparam logic [3:0] LEN_VERIFY    = 4'h9;
  localparam int         CMD_BYTES     = 9;
  localparam int         RES_BYTES     = 7;

  localparam int IDX_DRIVE  = 1;
  localparam int IDX_TRACK  = 2;
  localparam int IDX_HEAD   = 3;
  localparam int IDX_SECTOR = 4;
  localparam int IDX_SIZE   = 5;
  localparam int IDX_LAST   = 6;
  localparam int IDX_COUNT  = 8;

  localparam int BIT_WRITE_SEL = 6;
  localparam int BIT_MULTI     = 7;
  localparam int BIT_COUNT_EN  = 7;
  localparam int BIT_SEL2      = 2;
  localparam int BIT_DMA       = 0;
  localparam int HI_NIB_HI     = 7;
  localparam int HI_NIB_LO     = 4;
  localparam int LO_NIB_HI     = 3;

  localparam logic [7:0] ST0_ABNORMAL  = 8'h40;
  localparam logic [7:0] ST0_INVALID   = 8'h80;
  localparam logic [7:0] ST1_END_CYL   = 8'h80;
  localparam logic [7:0] ST1_DATA_ERR  = 8'h20;
  localparam logic [7:0] ST1_NO_DATA   = 8'h04;
  localparam logic [7:0] ST2_CTRL_MARK = 8'h40;
  localparam logic [7:0] FIRST_SECTOR  = 8'h01;

  localparam logic [8:0] VERIFY_FULL_COUNT = 9'h100;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_COLLECT    = 3'b001,
    ST_EXEC       = 3'b010,
    ST_MOTOR_WAIT = 3'b011,
    ST_SECTOR     = 3'b100,
    ST_RESULT     = 3'b101
  } cmd_state_e;

  typedef enum logic [1:0] {
    K_SPECIFY   = 2'b00,
    K_SET_TRACK = 2'b01,
    K_VERIFY    = 2'b10,
    K_INVALID   = 2'b11
  } cmd_kind_e;

  function automatic time_us_t scale_us(input time_us_t unit, input logic [7:0] factor);
    logic [TIME_W+7:0] prod;
    prod     = unit * factor;
    scale_us = prod[TIME_W-1:0];
  endfunction : scale_us

  function automatic logic [7:0] make_st0(input logic [7:0] code, input logic head,
                                          input logic [1:0] drive);
    make_st0 = code | {5'h00, head, drive};
  endfunction : make_st0

endpackage : fdc_cmd_pkg

//--- hw/fdc_track_specify_verify_cmds.sv
// Command interpreter for track set/read, timing parameters and verify
module fdc_track_specify_verify_cmds
  import fdc_cmd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             cmd_valid_i,
  input  wire logic [7:0]       cmd_byte_i,
  output logic                  cmd_ready_o,
  output logic                  res_valid_o,
  output logic [7:0]            res_byte_o,
  input  wire logic             res_ready_i,
  input  wire logic [1:0]       data_rate_i,
  input  wire logic             motor_timer_range_i,
  input  wire logic             step_request_i,
  output logic                  step_pulse_o,
  input  wire logic             motor_select_i,
  output logic                  motor_ready_o,
  output logic                  motor_hold_o,
  input  wire logic [7:0]       sectors_per_side_i,
  output logic                  sec_req_o,
  output logic [1:0]            sec_drive_o,
  output logic                  sec_head_o,
  output logic [7:0]            sec_number_o,
  input  wire logic             sec_done_i,
  input  wire logic             sec_crc_err_i,
  input  wire logic             sec_not_found_i,
  input  wire logic             sec_deleted_i,
  input  wire logic             terminal_count_input_i,
  output logic                  non_dma_o,
  output logic [3:0]            step_interval_code_o,
  output logic [3:0][15:0]      present_track_o,
  output logic                  cmd_end_o
);

  delay_timer_if step_tif ();
  delay_timer_if on_tif ();
  delay_timer_if off_tif ();

  delay_timer #(.TICK_LEN(TICK_LEN)) u_step_timer (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .tif      (step_tif)
  );
  delay_timer #(.TICK_LEN(TICK_LEN)) u_on_timer (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .tif      (on_tif)
  );
  delay_timer #(.TICK_LEN(TICK_LEN)) u_off_timer (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .tif      (off_tif)
  );

  // Timing parameters: deliberately without reset
  logic [3:0] step_code_q, step_code_d;
  logic [3:0] off_factor_q, off_factor_d;
  logic [3:0] on_factor_q, on_factor_d;
  logic       non_dma_q, non_dma_d;

  cmd_state_e        state_q, state_d;
  cmd_kind_e         kind_q, kind_d;
  logic [3:0]        len_q, len_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        cmd_q [CMD_BYTES];
  logic [7:0]        cmd_d [CMD_BYTES];
  logic [7:0]        res_q [RES_BYTES];
  logic [7:0]        res_d [RES_BYTES];
  logic [2:0]        res_cnt_q, res_cnt_d;
  logic [3:0][15:0]  track_q, track_d;
  logic              head_q, head_d;
  logic [7:0]        sector_q, sector_d;
  logic [8:0]        done_cnt_q, done_cnt_d;
  logic              end_q, end_d;
  logic              hold_q, hold_d;
  logic              ready_q, ready_d;
  logic              sel_prev_q;
  logic              step_q, step_d;

  // Decoded verify and track parameters, valid while the bytes sit in cmd_q
  logic [1:0] v_drive;
  logic       v_count_en;
  logic       v_multi;
  logic [7:0] v_last;
  logic [8:0] v_target;
  logic [8:0] v_next_cnt;
  logic [1:0] t_drive;
  logic       t_sel_hi;
  logic [7:0] t_old;
  logic [7:0] t_new;

  always_comb begin
    v_drive    = cmd_q[IDX_DRIVE][1:0];
    v_count_en = cmd_q[IDX_DRIVE][BIT_COUNT_EN];
    v_multi    = cmd_q[0][BIT_MULTI];
    v_last     = cmd_q[IDX_LAST];
    // Zero count means a full 256-sector pass
    v_target   = (cmd_q[IDX_COUNT] == 8'h00) ? VERIFY_FULL_COUNT
                                              : {1'b0, cmd_q[IDX_COUNT]};
    v_next_cnt = done_cnt_q + 9'h001;
    t_drive    = cmd_q[IDX_DRIVE][1:0];
    t_sel_hi   = cmd_q[IDX_DRIVE][BIT_SEL2];
    t_old      = t_sel_hi ? track_q[t_drive][15:8] : track_q[t_drive][7:0];
    t_new      = cmd_q[IDX_TRACK];
  end

  // Load the seven verify result bytes and end the command
  function automatic void finish_verify(input logic [7:0] st0, input logic [7:0] st1,
                                        input logic [7:0] st2);
    res_d[0]  = st0;
    res_d[1]  = st1;
    res_d[2]  = st2;
    res_d[3]  = cmd_q[IDX_TRACK];
    res_d[4]  = {7'h00, head_d};
    res_d[5]  = sector_d;
    res_d[6]  = cmd_q[IDX_SIZE];
    res_cnt_d = 3'(RES_BYTES);
    state_d   = ST_RESULT;
    end_d     = 1'b1;
  endfunction : finish_verify

  always_comb begin
    state_d      = state_q;
    kind_d       = kind_q;
    len_d        = len_q;
    cnt_d        = cnt_q;
    cmd_d        = cmd_q;
    res_d        = res_q;
    res_cnt_d    = res_cnt_q;
    track_d      = track_q;
    head_d       = head_q;
    sector_d     = sector_q;
    done_cnt_d   = done_cnt_q;
    end_d        = 1'b0;
    hold_d       = hold_q;
    step_code_d  = step_code_q;
    off_factor_d = off_factor_q;
    on_factor_d  = on_factor_q;
    non_dma_d    = non_dma_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          cmd_d[0] = cmd_byte_i;
          cnt_d    = 4'h1;
          if (cmd_byte_i == OP_SPECIFY) begin
            kind_d  = K_SPECIFY;
            len_d   = LEN_SPECIFY;
            state_d = ST_COLLECT;
          end else if ((cmd_byte_i & SET_TRACK_MASK) == OP_SET_TRACK) begin
            kind_d  = K_SET_TRACK;
            len_d   = LEN_SET_TRACK;
            state_d = ST_COLLECT;
          end else if ((cmd_byte_i & VERIFY_MASK) == OP_VERIFY) begin
            kind_d  = K_VERIFY;
            len_d   = LEN_VERIFY;
            state_d = ST_COLLECT;
          end else begin
            // Opcodes not handled here answer with the invalid status byte
            kind_d    = K_INVALID;
            res_d[0]  = ST0_INVALID;
            res_cnt_d = 3'h1;
            state_d   = ST_RESULT;
          end
        end
      end
      ST_COLLECT: begin
        if (cmd_valid_i) begin
          cmd_d[cnt_q] = cmd_byte_i;
          cnt_d        = cnt_q + 4'h1;
          if (cnt_q == len_q - 4'h1) begin
            state_d = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        case (kind_q)
          K_SPECIFY: begin
            // No result bytes, no interrupt: just the timing registers
            step_code_d  = cmd_q[IDX_DRIVE][HI_NIB_HI:HI_NIB_LO];
            off_factor_d = cmd_q[IDX_DRIVE][LO_NIB_HI:0];
            on_factor_d  = cmd_q[IDX_TRACK][LO_NIB_HI:0];
            non_dma_d    = cmd_q[IDX_TRACK][BIT_DMA];
            state_d      = ST_IDLE;
          end
          K_SET_TRACK: begin
            res_d[0] = t_old;
            if (cmd_q[0][BIT_WRITE_SEL]) begin
              res_d[0] = t_new;
              if (t_sel_hi) begin
                track_d[t_drive][15:8] = t_new;
              end else begin
                track_d[t_drive][7:0] = t_new;
              end
            end
            res_cnt_d = 3'h1;
            state_d   = ST_RESULT;
          end
          K_VERIFY: begin
            head_d     = cmd_q[IDX_DRIVE][BIT_SEL2];
            sector_d   = cmd_q[IDX_SECTOR];
            done_cnt_d = '0;
            hold_d     = 1'b1;
            if (v_last > sectors_per_side_i) begin
              // Rejected before any sector is read, so no mark data
              finish_verify(make_st0(ST0_ABNORMAL, head_d, v_drive), ST1_END_CYL, 8'h00);
            end else begin
              state_d = ST_MOTOR_WAIT;
            end
          end
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end
      ST_MOTOR_WAIT: begin
        // Pre-command motor delay gates the first sector read
        if (ready_q) begin
          state_d = ST_SECTOR;
        end
      end
      ST_SECTOR: begin
        // Sector checks only; nothing is forwarded to the host
        if (sec_done_i) begin
          if (sec_not_found_i || sec_crc_err_i || sec_deleted_i) begin
            finish_verify(make_st0(ST0_ABNORMAL, head_q, v_drive),
                          sec_not_found_i ? ST1_NO_DATA : (sec_crc_err_i ? ST1_DATA_ERR
                                                                           : 8'h00),
                          sec_deleted_i ? ST2_CTRL_MARK : 8'h00);
          end else begin
            done_cnt_d = v_next_cnt;
            // Terminal count input plays no part here
            if (v_count_en && v_next_cnt == v_target) begin
              finish_verify(make_st0(8'h00, head_q, v_drive), 8'h00, 8'h00);
            end else if (!v_count_en && sector_q == v_last) begin
              finish_verify(make_st0(8'h00, head_q, v_drive), 8'h00, 8'h00);
            end else if (sector_q == v_last) begin
              if (v_multi && !head_q) begin
                head_d   = 1'b1;
                sector_d = FIRST_SECTOR;
              end else begin
                finish_verify(make_st0(ST0_ABNORMAL, head_q, v_drive), ST1_END_CYL, 8'h00);
              end
            end else begin
              sector_d = sector_q + 8'h01;
            end
          end
        end
      end
      ST_RESULT: begin
        if (res_ready_i) begin
          for (int i = 0; i < RES_BYTES - 1; i++) begin
            res_d[i] = res_q[i+1];
          end
          res_d[RES_BYTES-1] = 8'h00;
          res_cnt_d          = res_cnt_q - 3'h1;
          if (res_cnt_q == 3'h1) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Post-command delay expiry releases the motor hold; a stale expiry
    // must not drop the hold of a verify in progress
    if (off_tif.done && !(kind_q == K_VERIFY &&
                          state_q inside {ST_EXEC, ST_MOTOR_WAIT, ST_SECTOR})) begin
      hold_d = 1'b0;
    end
  end

  // Step pulses spaced by the programmed interval
  always_comb begin
    step_d         = step_request_i && !step_tif.busy && !step_q;
    step_tif.start = step_d;
    step_tif.load_us = scale_us(STEP_UNIT_US[data_rate_i],
                                STEP_CODE_SPAN - {4'h0, step_code_q});
  end

  // Motor delays with rate and range constants
  always_comb begin
    on_tif.start    = motor_select_i && !sel_prev_q;
    on_tif.load_us  = scale_us(ON_UNIT_US[motor_timer_range_i][data_rate_i],
                               (on_factor_q == 4'h0) ? ON_FACTOR_ZERO
                                                     : {4'h0, on_factor_q});
    off_tif.start   = end_q && (kind_q == K_VERIFY);
    off_tif.load_us = scale_us(OFF_UNIT_US[motor_timer_range_i][data_rate_i],
                               (off_factor_q == 4'h0) ? OFF_FACTOR_ZERO
                                                      : {4'h0, off_factor_q});
    ready_d = motor_select_i && (ready_q || on_tif.done);
  end

  always_ff @(posedge clock_i) begin
    step_code_q  <= step_code_d;
    off_factor_q <= off_factor_d;
    on_factor_q  <= on_factor_d;
    non_dma_q    <= non_dma_d;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q    <= ST_IDLE;
      kind_q     <= K_INVALID;
      len_q      <= '0;
      cnt_q      <= '0;
      cmd_q      <= '{default: 8'h00};
      res_q      <= '{default: 8'h00};
      res_cnt_q  <= '0;
      track_q    <= '0;
      head_q     <= 1'b0;
      sector_q   <= '0;
      done_cnt_q <= '0;
      end_q      <= 1'b0;
      hold_q     <= 1'b0;
      ready_q    <= 1'b0;
      sel_prev_q <= 1'b0;
      step_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      kind_q     <= kind_d;
      len_q      <= len_d;
      cnt_q      <= cnt_d;
      cmd_q      <= cmd_d;
      res_q      <= res_d;
      res_cnt_q  <= res_cnt_d;
      track_q    <= track_d;
      head_q     <= head_d;
      sector_q   <= sector_d;
      done_cnt_q <= done_cnt_d;
      end_q      <= end_d;
      hold_q     <= hold_d;
      ready_q    <= ready_d;
      sel_prev_q <= motor_select_i;
      step_q     <= step_d;
    end
  end

  assign cmd_ready_o          = (state_q == ST_IDLE) || (state_q == ST_COLLECT);
  assign res_valid_o          = (state_q == ST_RESULT);
  assign res_byte_o           = res_q[0];
  assign step_pulse_o         = step_q;
  assign motor_ready_o        = ready_q;
  assign motor_hold_o         = hold_q;
  assign sec_req_o            = (state_q == ST_SECTOR);
  assign sec_drive_o          = v_drive;
  assign sec_head_o           = head_q;
  assign sec_number_o         = sector_q;
  assign non_dma_o            = non_dma_q;
  assign step_interval_code_o = step_code_q;
  assign present_track_o      = track_q;
  assign cmd_end_o            = end_q;

endmodule : fdc_track_specify_verify_cmds

//--- test/fdc_cmd_monitor.sv
// Concurrent checks on the command interpreter ports
module fdc_cmd_monitor (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cmd_ready_o,
  input wire logic res_valid_o,
  input wire logic step_pulse_o,
  input wire logic motor_select_i,
  input wire logic motor_ready_o,
  input wire logic motor_hold_o,
  input wire logic sec_req_o,
  input wire logic sec_done_i,
  input wire logic terminal_count_input_i,
  input wire logic cmd_end_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  chk_result_no_cmd: assert property (res_valid_o |-> !cmd_ready_o)
    else $error("result offered while taking commands");
  chk_step_gap: assert property (step_pulse_o |=> !step_pulse_o [*8])
    else $error("step pulses too close");
  chk_pre_delay: assert property ($rose(motor_select_i) |=> !motor_ready_o [*8])
    else $error("motor ready without delay");
  chk_sector_entry: assert property ($rose(sec_req_o) |-> $past(motor_ready_o))
    else $error("sector read before motor ready");
  chk_no_host_data: assert property (sec_req_o |-> !res_valid_o && !cmd_ready_o)
    else $error("host traffic during verify");
  chk_term_ignored: assert property (sec_req_o && terminal_count_input_i && !sec_done_i
    |=> sec_req_o)
    else $error("verify ended without sector");
  chk_end_result: assert property (cmd_end_o |-> ##[0:1] res_valid_o)
    else $error("verify end without result");
  chk_end_hold: assert property (cmd_end_o |-> motor_hold_o)
    else $error("motor hold dropped at verify end");
  cover property (cmd_end_o);
  cover property (step_pulse_o);
  cover property (sec_req_o && sec_done_i);
endmodule : fdc_cmd_monitor

//--- test/fdc_track_specify_verify_cmds_tb.sv
// Self-checking bench for the command interpreter
module fdc_track_specify_verify_cmds_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fdc_cmd_pkg::*;
  localparam int TL = 2;
  logic             clock_i, resetn_i, cmd_valid_i, res_ready_i, step_request_i;
  logic             cmd_ready_o, res_valid_o, step_pulse_o, motor_select_i, motor_ready_o;
  logic             sec_req_o, sec_done_i, non_dma_o, terminal_count_input_i;
  logic [7:0]       cmd_byte_i, res_byte_o, sectors_per_side_i, sec_number_o;
  logic [1:0]       data_rate_i, sec_drive_o;
  logic             sec_crc_err_i, sec_head_o;
  logic [3:0]       step_interval_code_o;
  logic [3:0][15:0] present_track_o;
  logic [15:0]      n_done;
  int               error_cnt, n_tests;
  fdc_track_specify_verify_cmds #(.TICK_LEN(TL)) DUT (.clock_i, .resetn_i, .cmd_valid_i,
    .cmd_byte_i, .cmd_ready_o, .res_valid_o, .res_byte_o, .res_ready_i, .data_rate_i,
    .motor_timer_range_i(1'b0), .step_request_i, .step_pulse_o, .motor_select_i,
    .motor_ready_o, .motor_hold_o(), .sectors_per_side_i, .sec_req_o, .sec_drive_o,
    .sec_head_o, .sec_number_o, .sec_done_i, .sec_crc_err_i,
    .sec_not_found_i(1'b0), .sec_deleted_i(1'b0), .terminal_count_input_i, .non_dma_o,
    .step_interval_code_o, .present_track_o, .cmd_end_o());
  sector_model u_sec (.clock_i, .resetn_i, .req_i(sec_req_o), .done_o(sec_done_i),
    .count_o(n_done));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
    end
  endtask : bound
  task automatic cyc;
    @(posedge clock_i);
    #1;
  endtask : cyc
  // Valid stays up across bytes so back-to-back bytes are exercised
  task automatic cmd(input logic [7:0] q [$]);
    foreach (q[k]) begin
      cmd_valid_i = 1'b1;
      cmd_byte_i  = q[k];
      for (int i = 0; i < 9000 && cmd_ready_o !== 1'b1; i++) cyc();
      bound(cmd_ready_o === 1'b1);
      cyc();
    end
    cmd_valid_i = 1'b0;
  endtask : cmd
  task automatic pops(input int n, input logic [7:0] q [$]);
    res_ready_i = 1'b1;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 9000 && res_valid_o !== 1'b1; i++) cyc();
      bound(res_valid_o === 1'b1);
      if (k < q.size()) chk(res_byte_o, q[k]);
      cyc();
    end
    res_ready_i = 1'b0;
  endtask : pops
  task automatic t_specify;
    cmd('{8'h03, 8'hf1, 8'h01});
    repeat (3) cyc();
    chk(step_interval_code_o, 4'hf);
    chk(non_dma_o, 1'b1);
    chk({res_valid_o, cmd_ready_o}, 2'h1);
    resetn_i = 1'b0;
    cyc();
    resetn_i = 1'b1;
    chk({non_dma_o, step_interval_code_o}, 5'h1f);
    cmd('{8'h10});
    pops(1, '{8'h80});
  endtask : t_specify
  task automatic t_track;
    cmd('{8'h61, 8'h36, 8'ha5});
    pops(1, '{8'ha5});
    chk(present_track_o[2], 16'ha500);
    cmd('{8'h21, 8'h36, 8'h00});
    pops(1, '{8'ha5});
    cmd('{8'h21, 8'h32, 8'h5a});
    pops(1, '{8'h00});
  endtask : t_track
  task automatic t_step(input logic [1:0] rate, input int us);
    int gap;
    data_rate_i    = rate;
    step_request_i = 1'b1;
    // An interval left running by an earlier call expires first
    cyc();
    for (int i = 0; i < 6000 && step_pulse_o !== 1'b1; i++) cyc();
    bound(step_pulse_o === 1'b1);
    cyc();
    gap = 1;
    for (; gap < 6000 && step_pulse_o !== 1'b1; gap++) cyc();
    step_request_i = 1'b0;
    chk(gap >= us * TL && gap <= us * TL + 4, 1'b1);
  endtask : t_step
  task automatic t_verify(input logic [7:0] b0, b1, last, cnt, sps, input logic [7:0] q [$],
                          input int nsec);
    logic [15:0] base;
    sectors_per_side_i = sps;
    base = n_done;
    cmd('{b0, b1, 8'h00, 8'h00, 8'h01, 8'h02, last, 8'h1b, cnt});
    pops(7, q);
    chk(n_done - base, nsec[15:0]);
    chk({sec_drive_o, sec_head_o, sec_number_o}, {5'h00, b1[1:0], q[4][0], q[5]});
  endtask : t_verify
  initial begin
    {resetn_i, cmd_valid_i, res_ready_i, step_request_i, motor_select_i} = 5'h0;
    {cmd_byte_i, sectors_per_side_i, terminal_count_input_i} = 17'h0;
    data_rate_i = 2'h3;
    sec_crc_err_i = 1'b0;
    {error_cnt, n_tests} = 64'h0;
    repeat (2) cyc();
    resetn_i = 1'b1;
    t_specify();
    t_track();
    t_step(2'h3, 500);
    t_step(2'h0, 1000);
    motor_select_i = 1'b1;
    terminal_count_input_i = 1'b1;
    t_verify(8'h16, 8'h80, 8'h12, 8'h03, 8'h12, '{0, 0, 0, 0, 0, 3, 2}, 3);
    t_verify(8'h16, 8'h00, 8'h02, 8'hff, 8'h12, '{0, 0, 0, 0, 0, 2, 2}, 2);
    t_verify(8'h96, 8'h80, 8'hff, 8'h00, 8'hff, '{4, 0, 0, 0, 1, 1, 2}, 256);
    sec_crc_err_i = 1'b1;
    t_verify(8'h16, 8'h00, 8'h02, 8'hff, 8'h12, '{8'h40, 8'h20, 0, 0, 0, 1, 2}, 1);
    sec_crc_err_i = 1'b0;
    t_verify(8'h16, 8'h05, 8'h13, 8'hff, 8'h12, '{8'h45, 8'h80, 0, 0, 1, 1, 2}, 0);
    final_report();
  end
endmodule : fdc_track_specify_verify_cmds_tb
bind fdc_track_specify_verify_cmds fdc_cmd_monitor u_mon (.clock_i, .resetn_i, .cmd_ready_o,
  .res_valid_o, .step_pulse_o, .motor_select_i, .motor_ready_o, .motor_hold_o, .sec_req_o,
  .sec_done_i, .terminal_count_input_i, .cmd_end_o);

//--- test/sector_model.sv
// Drive-side model that answers each sector request after a short read
module sector_model (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        req_i,
  output logic             done_o,
  output logic [15:0]      count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  // Only answers while asked, so stray pulses would show as miscounts
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q  <= 2'h0;
      done_o  <= 1'b0;
      count_o <= 16'h0;
    end else begin
      done_o  <= req_i && !done_o && wait_q == 2'h3;
      wait_q  <= (req_i && !done_o) ? wait_q + 2'h1 : 2'h0;
      count_o <= count_o + {15'h0, done_o};
    end
  end
endmodule : sector_model
